//--- rtl/ppo_cfg.svh
// Constants for the pin output override block
`ifndef PPO_CFG_SVH
`define PPO_CFG_SVH
`define PPO_ADDR_W 4
`define PPO_IOCON_ADDR 4'h0
`define PPO_UNLOCK_ADDR 4'h1
`define PPO_STATUS_ADDR 4'h2
`define PPO_CTRL_ADDR 4'h3
`define PPO_UNLOCK_KEY1 16'hAA55
`define PPO_UNLOCK_KEY2 16'h55AA
`define PPO_IOCON_RESET 16'h0000
`define PPO_OVREN_H_BIT 9
`define PPO_OVREN_L_BIT 8
`define PPO_OVERRIDE_PIN_VALUES_HI 7
`define PPO_OVERRIDE_PIN_VALUES_LO 6
`define PPO_FAULT_PIN_VALUES_HI 5
`define PPO_FAULT_PIN_VALUES_LO 4
`define PPO_LIMIT_PIN_VALUES_HI 3
`define PPO_LIMIT_PIN_VALUES_LO 2
`define PPO_FAULT_MODE_SELECT_BIT 0
`define PPO_LIMIT_MODE_SELECT_BIT 1
`endif

//--- rtl/ppo_pin_select.sv
// Per-pin source selection for one output pin
`timescale 1ns/1ps
`default_nettype none
module ppo_pin_select
  import ppo_pkg::*;
(
  input wire logic override_enable,
  input wire logic override_value,
  input wire logic fault_force,
  input wire logic fault_value,
  input wire logic limit_force,
  input wire logic limit_value,
  input wire logic pwm_value,
  output logic pin_nxt,
  output ppo_src_t src
);
  always_comb begin
    if (override_enable) begin
      pin_nxt = override_value; // [R08]
      src = PPO_SRC_OVERRIDE;
    end else if (fault_force) begin
      pin_nxt = fault_value; // [R04] [R08]
      src = PPO_SRC_FAULT;
    end else if (limit_force) begin
      pin_nxt = limit_value; // [R05] [R08]
      src = PPO_SRC_LIMIT;
    end else begin
      pin_nxt = pwm_value;
      src = PPO_SRC_PWM;
    end
  end
endmodule // ppo_pin_select
`default_nettype wire

//--- rtl/ppo_pkg.sv
// Types for the pin output override block
package ppo_pkg;
  typedef enum logic [1:0] {
    PPO_SRC_PWM,
    PPO_SRC_LIMIT,
    PPO_SRC_FAULT,
    PPO_SRC_OVERRIDE
  } ppo_src_t;
  typedef enum logic [1:0] {
    PPO_LOCKED,
    PPO_KEY1_SEEN,
    PPO_UNLOCKED
  } ppo_lock_t;
endpackage

//--- rtl/ppo_top.sv
// Pin output override block with register port and write lock
// Operation
// [R01] Low override enable set: low pin follows override value bit 0, else PWM.
// [R02] High override enable set: high pin follows override value bit 1, else PWM.
// [R03] Override value field is bits 7:6; upper bit high pin, lower bit low.
// [R04] Fault active with fault mode: pins take fault values, field bits 5:4.
// [R05] Limit active with limit mode: pins take limit values, field bits 3:2.
// [R06] Software should not change value fields after global enable is set.
// [R07] With write protect set, control writes need the unlock sequence first; the CTRL register here takes writes without it.
// [R08] Priority per pin: override, then fault, then limit, then PWM waveform.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ppo_cfg.svh"
module ppo_top
  import ppo_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [`PPO_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic write_protect_config,
  input wire logic module_global_enable,
  input wire logic pwm_high,
  input wire logic pwm_low,
  input wire logic fault_active,
  input wire logic limit_active,
  output logic high_side_output,
  output logic low_side_output
);
  ////////////////////////////////////////////////////////////////
  logic [15:0] pin_io_control_r;
  logic [1:0] ctrl_r;
  ppo_lock_t lock_r;
  logic high_nxt;
  logic low_nxt;
  ppo_src_t high_src;
  ppo_src_t low_src;
  logic iocon_hit;
  logic iocon_ok;
  logic fault_force;
  logic limit_force;

  assign iocon_hit = reg_wr && (reg_addr == `PPO_IOCON_ADDR);
  // Protected write is dropped silently and the unlock is spent
  assign iocon_ok = !write_protect_config || (lock_r == PPO_UNLOCKED); // [R07]
  assign fault_force = fault_active && ctrl_r[`PPO_FAULT_MODE_SELECT_BIT]; // [R04]
  assign limit_force = limit_active && ctrl_r[`PPO_LIMIT_MODE_SELECT_BIT]; // [R05]

  ////////////////////////////////////////////////////////////////
  // Unlock sequence: two keys back to back, good for one write
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lock_r <= PPO_LOCKED;
    end else if (iocon_hit) begin
      lock_r <= PPO_LOCKED; // [R07]
    end else if (reg_wr && reg_addr == `PPO_UNLOCK_ADDR) begin
      case (lock_r)
        PPO_LOCKED: lock_r <= (reg_wdata == `PPO_UNLOCK_KEY1) ? PPO_KEY1_SEEN : PPO_LOCKED;
        PPO_KEY1_SEEN: lock_r <= (reg_wdata == `PPO_UNLOCK_KEY2) ? PPO_UNLOCKED : PPO_LOCKED;
        default: lock_r <= lock_r;
      endcase
    end else if (reg_wr && lock_r == PPO_KEY1_SEEN) begin
      lock_r <= PPO_LOCKED; // [R07]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_io_control_r <= `PPO_IOCON_RESET;
    end else if (iocon_hit && iocon_ok) begin
      // Value fields stay writable after enable; software must leave them
      pin_io_control_r <= reg_wdata; // [R07] [R06]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= 2'h0;
    end else if (reg_wr && reg_addr == `PPO_CTRL_ADDR) begin
      ctrl_r <= reg_wdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  ppo_pin_select u_high (
    .override_enable(pin_io_control_r[`PPO_OVREN_H_BIT]), // [R02]
    .override_value(pin_io_control_r[`PPO_OVERRIDE_PIN_VALUES_HI]), // [R03]
    .fault_force(fault_force),
    .fault_value(pin_io_control_r[`PPO_FAULT_PIN_VALUES_HI]),
    .limit_force(limit_force),
    .limit_value(pin_io_control_r[`PPO_LIMIT_PIN_VALUES_HI]),
    .pwm_value(pwm_high),
    .pin_nxt(high_nxt),
    .src(high_src)
  );

  ppo_pin_select u_low (
    .override_enable(pin_io_control_r[`PPO_OVREN_L_BIT]), // [R01]
    .override_value(pin_io_control_r[`PPO_OVERRIDE_PIN_VALUES_LO]), // [R03]
    .fault_force(fault_force),
    .fault_value(pin_io_control_r[`PPO_FAULT_PIN_VALUES_LO]),
    .limit_force(limit_force),
    .limit_value(pin_io_control_r[`PPO_LIMIT_PIN_VALUES_LO]),
    .pwm_value(pwm_low),
    .pin_nxt(low_nxt),
    .src(low_src)
  );

  // Registered pins avoid glitches into the gate drivers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      high_side_output <= 1'b0;
      low_side_output <= 1'b0;
    end else begin
      high_side_output <= high_nxt; // [R02] [R04] [R05] [R08]
      low_side_output <= low_nxt; // [R01] [R04] [R05] [R08]
    end
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == `PPO_IOCON_ADDR) begin
        reg_rdata <= pin_io_control_r;
      end else if (reg_addr == `PPO_STATUS_ADDR) begin
        reg_rdata <= {5'h00, module_global_enable, lock_r, high_src, low_src,
                      fault_force, limit_force, high_side_output, low_side_output};
      end else if (reg_addr == `PPO_CTRL_ADDR) begin
        reg_rdata <= {14'h0000, ctrl_r};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule // ppo_top
`default_nettype wire

//--- tb/ppo_gate_drv.sv
// Gate driver model for the external switch pair
`timescale 1ns/1ps
`default_nettype none
module ppo_gate_drv (
  input wire logic clock,
  input wire logic hi_gate,
  input wire logic lo_gate,
  output logic node_r
);
  // Both gates on would short the rail, so the node holds
  always_ff @(posedge clock)
    if (hi_gate != lo_gate) node_r <= hi_gate;
endmodule // ppo_gate_drv
`default_nettype wire

//--- tb/ppo_top_monitor.sv
// Checker for pin source choice and write lock
`timescale 1ns/1ps
`default_nettype none
module ppo_mon (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic write_protect_config,
  input wire logic pwm_high,
  input wire logic pwm_low,
  input wire logic fault_active,
  input wire logic limit_active,
  input wire logic high_side_output,
  input wire logic low_side_output
);
  logic [15:0] io_r;
  logic [1:0] ct_r, lk_r;
  logic fh, fl, eh, el;
  logic [1:0] sh, sl;
  assign fh = fault_active & ct_r[0];
  assign fl = limit_active & ct_r[1];
  assign eh = io_r[9] ? io_r[7] : fh ? io_r[5] : fl ? io_r[3] : pwm_high;
  assign el = io_r[8] ? io_r[6] : fh ? io_r[4] : fl ? io_r[2] : pwm_low;
  assign sh = io_r[9] ? 2'h3 : fh ? 2'h2 : fl ? 2'h1 : 2'h0;
  assign sl = io_r[8] ? 2'h3 : fh ? 2'h2 : fl ? 2'h1 : 2'h0;
  // Unlock held until an IOCON write; a stray write only breaks a half sequence
  always_ff @(posedge clock or negedge rstn)
    if (!rstn) lk_r <= 2'h0;
    else if (reg_wr) lk_r <= reg_addr == 4'h0 ? 2'h0
      : reg_addr != 4'h1 ? (lk_r == 2'h1 ? 2'h0 : lk_r)
      : lk_r == 2'h2 ? 2'h2
      : lk_r == 2'h1 ? (reg_wdata == 16'h55AA ? 2'h2 : 2'h0)
      : reg_wdata == 16'hAA55 ? 2'h1 : 2'h0;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn) io_r <= 16'h0000;
    else if (reg_wr && reg_addr == 4'h0 && (!write_protect_config || lk_r == 2'h2))
      io_r <= reg_wdata;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn) ct_r <= 2'h0;
    else if (reg_wr && reg_addr == 4'h3) ct_r <= reg_wdata[1:0];
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_olo; io_r[8] |=> low_side_output == $past(io_r[6]); endproperty
  a_olo: assert property (p_olo) else $error("low override");
  property p_ohi; io_r[9] |=> high_side_output == $past(io_r[7]); endproperty
  a_ohi: assert property (p_ohi) else $error("high override");
  property p_rdb; reg_rd && reg_addr == 4'h0 |=> reg_rdata == $past(io_r); endproperty
  a_rdb: assert property (p_rdb) else $error("readback");
  property p_flt; !io_r[9] && fh |=> high_side_output == $past(io_r[5]); endproperty
  a_flt: assert property (p_flt) else $error("fault level");
  property p_lim; !io_r[8] && !fh && fl |=> low_side_output == $past(io_r[2]); endproperty
  a_lim: assert property (p_lim) else $error("limit level");
  property p_lck; reg_rd && reg_addr == 4'h2 |=> reg_rdata[9:8] == $past(lk_r); endproperty
  a_lck: assert property (p_lck) else $error("lock state");
  property p_pri; 1 |=> high_side_output == $past(eh) && low_side_output == $past(el); endproperty
  a_pri: assert property (p_pri) else $error("pin source");
  property p_sts; reg_rd && reg_addr == 4'h2 |=> reg_rdata[7:0] ==
    $past({sh, sl, fh, fl, high_side_output, low_side_output}); endproperty
  a_sts: assert property (p_sts) else $error("status sources");
endmodule // ppo_mon
bind ppo_top ppo_mon i_mon (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .write_protect_config, .pwm_high, .pwm_low, .fault_active, .limit_active,
  .high_side_output, .low_side_output);
`default_nettype wire

//--- tb/ppo_top_tb.sv
// Self-checking bench for the pin output override block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) n_checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", n, e, s); end
module ppo_top_tb;
  logic clock = 0, rstn = 0, reg_wr = 0, reg_rd = 0, wp = 0, ge = 0;
  logic ph = 0, pl = 0, fa = 0, la = 0, eh, el, hs, ls;
  logic [3:0] addr = 4'h0;
  logic [15:0] wd = 16'h0000, v, rdata, m_io;
  logic [1:0] m_ct, m_lk;
  int error_cnt = 0, n_checks = 0, seed = 32'h9f0332e3;
  ppo_top i_dut (.clock, .rstn, .reg_addr(addr), .reg_wdata(wd), .reg_wr, .reg_rd,
    .reg_rdata(rdata), .write_protect_config(wp), .module_global_enable(ge), .pwm_high(ph),
    .pwm_low(pl), .fault_active(fa), .limit_active(la), .high_side_output(hs),
    .low_side_output(ls));
  ppo_gate_drv i_drv (.clock, .hi_gate(hs), .lo_gate(ls), .node_r());
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #20 clock = ~clock;
  always @(posedge clock) {ph, pl, fa, la} <= 4'($random(seed));
  always @(posedge clock or negedge rstn)
    if (!rstn) begin
      {eh, el, m_lk, m_ct, m_io} <= 22'h000000;
    end else begin
      eh <= m_io[9] ? m_io[7] : fa & m_ct[0] ? m_io[5] : la & m_ct[1] ? m_io[3] : ph;
      el <= m_io[8] ? m_io[6] : fa & m_ct[0] ? m_io[4] : la & m_ct[1] ? m_io[2] : pl;
      if (reg_wr) begin
        m_lk <= addr == 4'h0 ? 2'h0
          : addr != 4'h1 ? (m_lk == 2'h1 ? 2'h0 : m_lk)
          : m_lk == 2'h2 ? 2'h2
          : m_lk == 2'h1 ? (wd == 16'h55AA ? 2'h2 : 2'h0)
          : wd == 16'hAA55 ? 2'h1 : 2'h0;
        if (addr == 4'h0 && (!wp || m_lk == 2'h2)) m_io <= wd;
        if (addr == 4'h3) m_ct <= wd[1:0];
      end
    end
  always @(negedge clock) if (rstn) begin
    `CHK("pins", {eh, el}, {hs, ls})
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    {reg_wr, addr, wd} <= {1'b1, a, d};
    @(posedge clock);
    reg_wr <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    {reg_rd, addr} <= {1'b1, a};
    @(posedge clock);
    reg_rd <= 1'b0;
    // Data stands for one cycle; taken before the next edge clears it
    @(posedge clock);
    v = rdata;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      wp <= i[1];
      wr(4'h3, 16'($random(seed)));
      // Reversed keys must leave the lock shut
      if (i[0]) wr(4'h1, i[2] ? 16'h55AA : 16'hAA55);
      if (i[0]) wr(4'h1, i[2] ? 16'hAA55 : 16'h55AA);
      rd(4'h2);
      `CHK("status", {ge, m_lk}, v[10:8])
      wr(4'h0, 16'($random(seed)));
      rd(4'h0);
      `CHK("iocon", m_io, v)
    end
    wr(4'h7, 16'hFFFF);
    rd(4'hF);
    `CHK("unmapped", 16'h0000, v)
    ge <= 1'b1;
    rd(4'h2);
    `CHK("enable", {ge, m_lk}, v[10:8])
    final_report;
  end
endmodule // ppo_top_tb
`default_nettype wire
